//--- afe_pkg.sv
// Shared constants for the sensor front-end control link
package afe_pkg;
  // ==========================================================
  // Bus addressing
  localparam logic [6:0] target_address     = 7'h48;
  localparam logic [7:0] reg_device_status  = 8'h00;
  localparam logic [7:0] reg_write_protect  = 8'h01;
  localparam logic [7:0] reg_gain_load      = 8'h10;
  localparam logic [7:0] reg_reference      = 8'h11;
  localparam logic [7:0] reg_operating_mode = 8'h12;
  // ==========================================================
  // Reset values
  localparam logic [7:0] rst_device_status  = 8'h00;
  localparam logic [7:0] rst_write_protect  = 8'h01;
  localparam logic [7:0] rst_gain_load      = 8'h03;
  localparam logic [7:0] rst_reference      = 8'h20;
  localparam logic [7:0] rst_operating_mode = 8'h00;
  localparam logic [7:0] ready_value        = 8'h01;
  // ==========================================================
  // Field positions
  localparam int lock_bit   = 0;
  localparam int short_bit  = 7;
  localparam int mode_lsb   = 0;
  localparam int mode_msb   = 2;
  localparam int intz_lsb   = 5;
  localparam int intz_msb   = 6;
  localparam logic [1:0] intz_bypass = 2'h3;
  // ==========================================================
  // Operating modes
  localparam logic [2:0] mode_deep_sleep = 3'h0;
  localparam logic [2:0] mode_galvanic   = 3'h1;
  localparam logic [2:0] mode_standby    = 3'h2;
  localparam logic [2:0] mode_three_lead = 3'h3;
  localparam logic [2:0] mode_temp_off   = 3'h6;
  localparam logic [2:0] mode_temp_on    = 3'h7;
  // ==========================================================
  // Timing
  localparam int clk_hz          = 25_000_000;
  localparam int scl_hz          = 100_000;
  localparam int scl_half_cycles = clk_hz / (2 * scl_hz);
  localparam int timeout_ms      = 25;
  localparam int timeout_cycles  = clk_hz / 1000 * timeout_ms;
  // ==========================================================
  // Controller register map over AXI4-Lite
  localparam logic [3:0] csr_command = 4'h0;
  localparam logic [3:0] csr_status  = 4'h4;
  localparam int cmd_go_bit    = 0;
  localparam int cmd_read_bit  = 1;
  localparam int cmd_sel_bit   = 2;
  localparam int cmd_ptr_lsb   = 8;
  localparam int cmd_data_lsb  = 16;
  localparam int st_busy_bit   = 0;
  localparam int st_nack_bit   = 1;
  localparam int st_data_lsb   = 8;
  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage

//--- afe_link_if.sv
// Two-wire link plus module select between controller and front-end
`timescale 1ns/1ps
interface afe_link_if;
  logic scl_o;     // Controller drives clock low when enabled
  logic scl_oe;
  logic sda_c_o;   // Controller data drive
  logic sda_c_oe;
  logic sda_d_o;   // Device data drive
  logic sda_d_oe;
  logic module_select_n;
  logic scl;       // Resolved wire levels, computed by the bench
  logic sda;
  modport controller (output scl_o, scl_oe, sda_c_o, sda_c_oe, module_select_n,
                      input scl, sda);
  modport device (output sda_d_o, sda_d_oe, input scl, sda, module_select_n);
endinterface

//--- sync2.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module sync2 #(
  parameter logic RESET_VALUE = 1'b1
) (
  input  wire logic aclk,    // Clock
  input  wire logic aresetn, // Sync reset, low
  input  wire logic d,       // Async input
  output logic      q        // Synchronised output
);
  logic meta;
  // Only the second stage reads the first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= RESET_VALUE;
      q    <= RESET_VALUE;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

//--- afe_device.sv
// Front-end device: two-wire target, register file and mode decode
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
module afe_device
  import afe_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = timeout_cycles
) (
  input  wire logic  aclk,                 // Clock
  input  wire logic  aresetn,              // Sync reset, low
  afe_link_if.device link,                 // Link pins
  output logic       current_amp_on,       // Current amplifier power
  output logic       control_amp_on,       // Control amplifier power
  output logic       bias_on,              // Bias circuitry power
  output logic       temp_sensor_on,       // Temperature sensor power
  output logic       temp_to_output,       // Sensor routed to analog output pin
  output logic       electrode_short_on,   // Electrode short switch
  output logic       zero_bypass,          // Internal zero divider bypassed
  output logic [7:0] gain_load_value,      // Gain/load setting
  output logic [7:0] reference_value       // Reference setting
);
  typedef enum {st_idle, st_addr, st_ack, st_rx, st_tx, st_txack} dev_state_t;

  logic       scl_s;
  logic       sda_s;
  logic       sel_n_s;
  logic       scl_d;
  logic       sda_d;
  dev_state_t state;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic [1:0] byte_idx;
  logic       rd_dir;
  logic       drive_low;
  logic [7:0] pointer;
  logic [7:0] status_reg;
  logic [7:0] protect_reg;
  logic [7:0] gain_reg;
  logic [7:0] ref_reg;
  logic [7:0] mode_reg;
  logic [31:0] scl_low_cnt;
  logic [31:0] sda_hold_cnt;
  logic        stuck;
  logic [7:0]  read_value;

  // ==========================================================
  // Pin synchronisers
  sync2 #(.RESET_VALUE(1'b1)) u_scl (.aclk(aclk), .aresetn(aresetn), .d(link.scl), .q(scl_s));
  sync2 #(.RESET_VALUE(1'b1)) u_sda (.aclk(aclk), .aresetn(aresetn), .d(link.sda), .q(sda_s));
  sync2 #(.RESET_VALUE(1'b1)) u_sel (.aclk(aclk), .aresetn(aresetn),
                                     .d(link.module_select_n), .q(sel_n_s));

  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire start_c  = scl_s && scl_d && sda_d && !sda_s && !sel_n_s;
  wire stop_c   = scl_s && scl_d && !sda_d && sda_s;

  // Edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // ==========================================================
  // Stuck-bus watchdogs; a stuck event drops the engine to idle
  always_ff @(posedge aclk) begin
    if (!aresetn || scl_s) begin
      scl_low_cnt <= '0;
    end else if (scl_low_cnt < 32'(TIMEOUT_CYCLES)) begin
      scl_low_cnt <= scl_low_cnt + 32'd1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !drive_low) begin
      sda_hold_cnt <= '0;
    end else if (sda_hold_cnt < 32'(TIMEOUT_CYCLES)) begin
      sda_hold_cnt <= sda_hold_cnt + 32'd1;
    end
  end

  assign stuck = (scl_low_cnt >= 32'(TIMEOUT_CYCLES)) ||
                 (sda_hold_cnt >= 32'(TIMEOUT_CYCLES));

  // Read mux; reserved locations return zero
  always_comb begin
    unique case (pointer)
      reg_device_status:  read_value = status_reg;
      reg_write_protect:  read_value = protect_reg;
      reg_gain_load:      read_value = gain_reg;
      reg_reference:      read_value = ref_reg;
      reg_operating_mode: read_value = mode_reg;
      default:            read_value = 8'h00;
    endcase
  end

  // ==========================================================
  // Target engine; samples on rising SCL, changes SDA on falling SCL
  always_ff @(posedge aclk) begin
    if (!aresetn || stuck || sel_n_s) begin
      state     <= st_idle;
      drive_low <= 1'b0;
      bitcnt    <= '0;
      byte_idx  <= '0;
      rd_dir    <= 1'b0;
      shreg     <= '0;
    end else if (start_c) begin
      state     <= st_addr;
      drive_low <= 1'b0;
      bitcnt    <= '0;
      byte_idx  <= '0;
    end else if (stop_c) begin
      state     <= st_idle;
      drive_low <= 1'b0;
    end else begin
      unique case (state)
        st_idle: ;
        st_addr, st_rx: begin
          if (scl_rise) begin
            shreg  <= {shreg[6:0], sda_s};
            bitcnt <= bitcnt + 4'd1;
          end else if (scl_fall && bitcnt == 4'd8) begin
            bitcnt <= '0;
            if (state == st_addr) begin
              rd_dir <= shreg[0];
              if (shreg[7:1] == target_address) begin
                drive_low <= 1'b1;
                state     <= st_ack;
              end else begin
                state <= st_idle;
              end
            end else begin
              drive_low <= 1'b1;
              state     <= st_ack;
            end
          end
        end
        st_ack: begin
          if (scl_fall) begin
            drive_low <= 1'b0;
            if (rd_dir) begin
              shreg     <= read_value;
              drive_low <= !read_value[7];
              state     <= st_tx;
            end else begin
              state <= st_rx;
            end
            if (byte_idx != 2'd3) begin
              byte_idx <= byte_idx + 2'd1;
            end
          end
        end
        st_tx: begin
          if (scl_fall) begin
            bitcnt <= bitcnt + 4'd1;
            if (bitcnt == 4'd7) begin
              drive_low <= 1'b0;
              state     <= st_txack;
            end else begin
              drive_low <= !shreg[6];
              shreg     <= {shreg[6:0], 1'b0};
            end
          end
        end
        st_txack: begin
          if (scl_rise) begin
            state <= st_idle; // Single byte reads end here
          end
        end
      endcase
    end
  end

  wire byte_done = state == st_rx && scl_fall && bitcnt == 4'd8 && !sel_n_s &&
                   !stuck && !start_c && !stop_c;

  // ==========================================================
  // Pointer and registers written over the bus; status_reg loads ready_value on its own
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pointer     <= 8'h00;
      status_reg  <= rst_device_status;
      protect_reg <= rst_write_protect;
      gain_reg    <= rst_gain_load;
      ref_reg     <= rst_reference;
      mode_reg    <= rst_operating_mode;
    end else begin
      status_reg <= ready_value;
      if (byte_done && byte_idx == 2'd1) begin
        pointer <= shreg;
      end else if (byte_done && byte_idx == 2'd2) begin
        unique case (pointer)
          reg_write_protect:  protect_reg <= shreg;
          reg_gain_load:      if (!protect_reg[lock_bit]) gain_reg <= shreg;
          reg_reference:      if (!protect_reg[lock_bit]) ref_reg <= shreg;
          reg_operating_mode: mode_reg <= shreg;
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // Mode decode into power controls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      current_amp_on     <= 1'b0;
      control_amp_on     <= 1'b0;
      bias_on            <= 1'b0;
      temp_sensor_on     <= 1'b0;
      temp_to_output     <= 1'b0;
      electrode_short_on <= 1'b0;
      zero_bypass        <= 1'b0;
      gain_load_value    <= rst_gain_load;
      reference_value    <= rst_reference;
    end else begin
      gain_load_value    <= gain_reg;
      reference_value    <= ref_reg;
      current_amp_on     <= 1'b0;
      control_amp_on     <= 1'b0;
      bias_on            <= 1'b0;
      temp_sensor_on     <= 1'b0;
      temp_to_output     <= 1'b0;
      electrode_short_on <= 1'b0;
      zero_bypass        <= ref_reg[intz_msb:intz_lsb] == intz_bypass;
      unique case (mode_reg[mode_msb:mode_lsb])
        mode_deep_sleep: electrode_short_on <= mode_reg[short_bit];
        mode_standby:    control_amp_on <= 1'b1;
        mode_three_lead: begin
          control_amp_on <= 1'b1;
          current_amp_on <= 1'b1;
          bias_on        <= 1'b1;
        end
        mode_temp_off: begin
          control_amp_on <= 1'b1;
          temp_sensor_on <= 1'b1;
          temp_to_output <= 1'b1;
        end
        mode_temp_on: begin
          control_amp_on <= 1'b1;
          current_amp_on <= 1'b1;
          bias_on        <= 1'b1;
          temp_sensor_on <= 1'b1;
          temp_to_output <= 1'b1;
        end
        mode_galvanic: begin
          current_amp_on <= 1'b1;
          zero_bypass    <= 1'b1;
        end
        default: ; // Undefined codes leave everything off except zero_bypass, which follows ref_reg
      endcase
    end
  end

  assign link.sda_d_o  = 1'b0;
  assign link.sda_d_oe = drive_low;
endmodule

//--- afe_controller.sv
// Link controller: AXI4-Lite registers driving one transfer at a time
`timescale 1ns/1ps
module afe_controller
  import afe_pkg::*;
(
  input  wire logic      aclk,          // Clock
  input  wire logic      aresetn,       // Sync reset, low
  afe_link_if.controller link,          // Link pins
  input  wire logic [3:0]  s_awaddr,    // Write address
  input  wire logic        s_awvalid,   // Write address valid
  output logic             s_awready,   // Write address ready
  input  wire logic [31:0] s_wdata,     // Write data
  input  wire logic [3:0]  s_wstrb,     // Write strobes
  input  wire logic        s_wvalid,    // Write data valid
  output logic             s_wready,    // Write data ready
  output logic [1:0]       s_bresp,     // Write response
  output logic             s_bvalid,    // Write response valid
  input  wire logic        s_bready,    // Write response ready
  input  wire logic [3:0]  s_araddr,    // Read address
  input  wire logic        s_arvalid,   // Read address valid
  output logic             s_arready,   // Read address ready
  output logic [31:0]      s_rdata,     // Read data
  output logic [1:0]       s_rresp,     // Read response
  output logic             s_rvalid,    // Read response valid
  input  wire logic        s_rready     // Read response ready
);
  typedef enum {c_idle, c_start, c_bit, c_ack, c_rstart, c_stop, c_done} ctl_state_t;

  ctl_state_t  state;
  logic        aw_got;
  logic        w_got;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  logic        w_strb0;
  logic        busy;
  logic        nack;
  logic        do_read;
  logic [7:0]  ptr;
  logic [7:0]  wdat;
  logic [7:0]  rdat;
  logic [7:0]  shreg;
  logic [3:0]  bitn;
  logic [1:0]  byte_n;
  logic [1:0]  phase;
  logic [7:0]  tick_cnt;
  logic        tick;
  logic        sda_s;

  sync2 #(.RESET_VALUE(1'b1)) u_sda (.aclk(aclk), .aresetn(aresetn), .d(link.sda), .q(sda_s));

  // ==========================================================
  // Quarter-bit tick rounded up, so SCL never runs above standard mode
  always_ff @(posedge aclk) begin
    if (!aresetn || tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 8'd1;
    end
  end
  assign tick = tick_cnt == 8'((scl_half_cycles + 1) / 2 - 1);

  // ==========================================================
  // AXI4-Lite write side; address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got  <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb0 <= 1'b0;
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_bvalid <= 1'b0;
      s_bresp <= resp_okay;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_awaddr;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_got <= 1'b1;
        w_data <= s_wdata;
        w_strb0 <= s_wstrb[0]; // Strobe is payload, gone after the handshake
        s_wready <= 1'b0;
      end
      if (aw_got && w_got && !s_bvalid) begin
        s_bvalid <= 1'b1;
        s_bresp <= (aw_addr == csr_command || aw_addr == csr_status) ? resp_okay : resp_slverr;
      end
      if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end
  wire cmd_write = aw_got && w_got && !s_bvalid && aw_addr == csr_command && w_strb0;

  // AXI4-Lite read side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= resp_okay;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rresp <= (s_araddr == csr_command || s_araddr == csr_status) ? resp_okay : resp_slverr;
      s_rdata <= (s_araddr == csr_status) ?
                 {16'h0000, rdat, 6'h00, nack, busy} :
                 (s_araddr == csr_command) ? {8'h00, wdat, ptr, 7'h00, busy} : 32'h0000_0000;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  // ==========================================================
  // Link sequencer; phase 0..3 per bit: low, set, rise, high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= c_idle;
      busy <= 1'b0;
      nack <= 1'b0;
      do_read <= 1'b0;
      ptr <= '0;
      wdat <= '0;
      rdat <= '0;
      shreg <= '0;
      bitn <= '0;
      byte_n <= '0;
      phase <= '0;
      link.scl_oe <= 1'b0;
      link.sda_c_oe <= 1'b0;
      link.module_select_n <= 1'b1;
    end else if (state == c_idle) begin
      if (cmd_write && w_data[cmd_go_bit] && !busy) begin
        busy <= 1'b1;
        nack <= 1'b0;
        do_read <= w_data[cmd_read_bit];
        ptr <= w_data[cmd_ptr_lsb +: 8];
        wdat <= w_data[cmd_data_lsb +: 8];
        link.module_select_n <= 1'b0;
        phase <= '0;
        state <= c_start;
      end
    end else if (tick) begin
      phase <= phase + 2'd1;
      unique case (state)
        c_start: if (phase == 2'd3) begin
          link.sda_c_oe <= 1'b1; // Start: SDA falls while SCL high
          shreg <= {target_address, 1'b0};
          byte_n <= '0;
          bitn <= '0;
          state <= c_bit;
        end
        c_bit: begin
          if (phase == 2'd0) link.scl_oe <= 1'b1;
          if (phase == 2'd1) link.sda_c_oe <= (byte_n == 2'd3) ? 1'b0 : !shreg[7];
          if (phase == 2'd2) link.scl_oe <= 1'b0;
          if (phase == 2'd3) begin
            if (byte_n == 2'd3) rdat <= {rdat[6:0], sda_s};
            shreg <= {shreg[6:0], 1'b0};
            bitn <= bitn + 4'd1;
            if (bitn == 4'd7) state <= c_ack;
          end
        end
        c_ack: begin
          if (phase == 2'd0) link.scl_oe <= 1'b1;
          if (phase == 2'd1) link.sda_c_oe <= 1'b0; // Release, or nack the read byte
          if (phase == 2'd2) link.scl_oe <= 1'b0;
          if (phase == 2'd3) begin
            bitn <= '0;
            if (byte_n != 2'd3 && sda_s) begin
              nack <= 1'b1;
              state <= c_stop;
            end else if (byte_n == 2'd0 || (byte_n == 2'd2 && do_read)) begin
              shreg <= (byte_n == 2'd0) ? ptr : {target_address, 1'b1};
              byte_n <= (byte_n == 2'd0) ? 2'd1 : 2'd3;
              state <= c_bit;
            end else if (byte_n == 2'd1) begin
              if (do_read) begin
                state <= c_rstart;
              end else begin
                shreg <= wdat;
                byte_n <= 2'd2;
                state <= c_bit;
              end
            end else begin
              state <= c_stop;
            end
          end
        end
        c_rstart: begin
          if (phase == 2'd0) link.scl_oe <= 1'b1;
          if (phase == 2'd1) link.sda_c_oe <= 1'b0;
          if (phase == 2'd2) link.scl_oe <= 1'b0;
          if (phase == 2'd3) begin
            link.sda_c_oe <= 1'b1; // Repeated start
            byte_n <= 2'd2;
            shreg <= {target_address, 1'b1};
            state <= c_bit;
          end
        end
        c_stop: begin
          if (phase == 2'd0) link.scl_oe <= 1'b1;
          if (phase == 2'd1) link.sda_c_oe <= 1'b1;
          if (phase == 2'd2) link.scl_oe <= 1'b0;
          if (phase == 2'd3) begin
            link.sda_c_oe <= 1'b0; // Stop: SDA rises while SCL high
            state <= c_done;
          end
        end
        c_done: if (phase == 2'd3) begin
          link.module_select_n <= 1'b1;
          busy <= 1'b0;
          state <= c_idle;
        end
        default: state <= c_idle;
      endcase
    end
  end

  assign link.scl_o   = 1'b0;
  assign link.sda_c_o = 1'b0;
endmodule

//--- afe_link_asserts.sv
// Checker for the two-wire link between controller and device
`timescale 1ns/1ps
module afe_link_asserts #(
  parameter int TIMEOUT_CYCLES = 2000
) (
  input wire logic aclk,            // Clock
  input wire logic aresetn,         // Sync reset, low
  input wire logic scl,             // Resolved clock wire
  input wire logic sda,             // Resolved data wire
  input wire logic sda_d_o,         // Device data drive
  input wire logic sda_d_oe,        // Device pulls data low
  input wire logic module_select_n  // Select, low
);
  int lo_cnt;
  int hold_cnt;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Stuck-line counters; margin covers the pin synchronisers
  always_ff @(posedge aclk) begin
    lo_cnt <= (!aresetn || scl) ? 0 : lo_cnt + 1;
  end
  always_ff @(posedge aclk) begin
    hold_cnt <= (!aresetn || !sda_d_oe) ? 0 : hold_cnt + 1;
  end
  // ==========================================================
  // Wire properties
  drain_only_a: assert property (sda_d_oe |-> !sda_d_o)
    else $error("device drives data high");
  idle_unsel_a: assert property (module_select_n [*6] |-> !sda_d_oe)
    else $error("device drives while unselected");
  hold_limit_a: assert property (hold_cnt <= TIMEOUT_CYCLES + 8)
    else $error("device holds data too long");
  scl_stuck_a: assert property (lo_cnt > TIMEOUT_CYCLES + 8 |-> !sda_d_oe)
    else $error("no release on stuck clock");
  ack_edge_a: assert property ($rose(sda_d_oe) |-> !scl)
    else $error("device drive starts with clock high");
  rel_edge_a: assert property ($fell(sda_d_oe) |-> !scl)
    else $error("device release with clock high");
  frame_sel_a: assert property ($changed(sda) && scl && $past(scl) |-> !module_select_n)
    else $error("start or stop without select");
  scl_rate_a: assert property ($rose(scl) |-> ##120 scl)
    else $error("clock high phase too short");
endmodule

//--- tb.sv
// Bench driving the controller registers and watching the device
`timescale 1ns/1ps
module tb;
  import afe_pkg::*;
  localparam logic [7:0] mv [7] = '{8'h80, 8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h00};
  localparam logic [6:0] mm [7] = '{7'h6a, 7'h21, 7'h68, 7'h78, 7'h6c, 7'h7c, 7'h6a};
  localparam logic [6:0] me [7] = '{7'h02, 7'h01, 7'h20, 7'h70, 7'h2c, 7'h7c, 7'h00};
  // Must exceed the longest legal low hold: ack plus eight zero bits
  localparam int stuck_cycles = 3000;
  logic        aclk = 0, aresetn = 0;
  logic [3:0]  s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'hf;
  logic [31:0] s_wdata = 32'h0000_0000, s_rdata;
  logic        s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]  s_bresp, s_rresp;
  wire  [6:0]  outs;
  wire  [7:0]  gain, refv;
  int          n_fail = 0, cmp_count = 0;
  logic        scl_hold = 1'b0;
  afe_link_if link();
  // Pull-ups on both wires
  assign link.scl = !(link.scl_oe | scl_hold); // Hold models a stuck clock line
  assign link.sda = !(link.sda_c_oe | link.sda_d_oe);
  afe_controller afe_controller_i (.aclk, .aresetn, .link(link.controller), .s_awaddr,
    .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
    .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
  afe_device #(.TIMEOUT_CYCLES(stuck_cycles)) afe_device_i (.aclk, .aresetn, .link(link.device),
    .current_amp_on(outs[6]), .control_amp_on(outs[5]), .bias_on(outs[4]),
    .temp_sensor_on(outs[3]), .temp_to_output(outs[2]), .electrode_short_on(outs[1]),
    .zero_bypass(outs[0]), .gain_load_value(gain), .reference_value(refv));
  afe_link_asserts #(.TIMEOUT_CYCLES(stuck_cycles)) afe_link_asserts_i (.aclk, .aresetn,
    .scl(link.scl), .sda(link.sda), .sda_d_o(link.sda_d_o), .sda_d_oe(link.sda_d_oe),
    .module_select_n(link.module_select_n));
  // ==========================================================
  // Clock and shared tasks
  initial begin
    forever #20 aclk = ~aclk;
  end
  task automatic complete_run();
    if (n_fail == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bounds every wait so a hang ends the run
  task automatic guard(input int n);
    if (n > 20000) begin
      n_fail++;
      complete_run();
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1;
    s_wvalid <= 1;
    s_bready <= 1;
    for (int n = 0; !(s_bvalid && s_bready); n++) begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 0;
      if (s_wready) s_wvalid <= 0;
      guard(n);
    end
    r = s_bresp;
    s_bready <= 0;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1;
    s_rready <= 1;
    for (int n = 0; !(s_rvalid && s_rready); n++) begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 0;
      guard(n);
    end
    d = s_rdata;
    r = s_rresp;
    s_rready <= 0;
  endtask
  // One link transfer, polled until the controller is idle
  task automatic xfer(input logic rd, input logic [7:0] p, d, output logic [7:0] q);
    logic [31:0] s;
    logic [1:0]  r;
    axi_wr(csr_command, {8'h00, d, p, 6'h00, rd, 1'b1}, r);
    s = 32'h0000_0001;
    for (int n = 0; s[st_busy_bit]; n++) begin
      axi_rd(csr_status, s, r);
      guard(n);
    end
    chk(32'(s[st_nack_bit]), 32'h0000_0000);
    q = s[15:8];
  endtask
  // Clock held low during the address ack; device must let go and drop the frame
  task automatic stuck_clock();
    logic [31:0] s;
    logic [1:0]  r;
    axi_wr(csr_command, {8'h00, 8'h00, reg_gain_load, 8'h01}, r);
    for (int n = 0; !link.sda_d_oe; n++) begin
      @(posedge aclk);
      guard(n);
    end
    scl_hold <= 1'b1;
    repeat (stuck_cycles + 16) @(posedge aclk);
    chk(32'(link.sda_d_oe), 32'h0000_0000);
    // Let go only while the controller pulls low, so no short high phase
    for (int n = 0; !link.scl_oe; n++) begin
      @(posedge aclk);
      guard(n);
    end
    scl_hold <= 1'b0;
    s = 32'h0000_0001;
    for (int n = 0; s[st_busy_bit]; n++) begin
      axi_rd(csr_status, s, r);
      guard(n);
    end
    chk(32'(s[st_nack_bit]), 32'h0000_0001);
    chk(32'(gain), 32'h0000_001c);
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    logic [7:0]  q;
    logic [1:0]  r;
    logic [31:0] d;
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    chk(32'({outs, gain, refv}), 32'({7'h00, rst_gain_load, rst_reference}));
    xfer(1, reg_device_status, 8'h00, q);
    chk(32'(q[0]), 32'h0000_0001);
    xfer(0, reg_gain_load, 8'h1c, q);
    xfer(1, reg_gain_load, 8'h00, q);
    chk(32'(q), 32'(rst_gain_load));
    xfer(0, reg_write_protect, 8'h00, q);
    xfer(0, reg_gain_load, 8'h1c, q);
    chk(32'(gain), 32'h0000_001c);
    stuck_clock();
    // Every mode, deep sleep first with the short switch enabled
    for (int i = 0; i < 7; i++) begin
      xfer(0, reg_operating_mode, mv[i], q);
      chk(32'(outs & mm[i]), 32'(me[i]));
    end
    axi_rd(4'h8, d, r);
    chk(32'(r), 32'(resp_slverr));
    chk(d, 32'h0000_0000);
    complete_run();
  end
endmodule
